/* File: phy_control_defines.svh */
// phy control register constants: address, field positions, reset value
// assumes inclusion by the design module only; the package does not include it
`ifndef PHY_CONTROL_DEFINES_SVH
`define PHY_CONTROL_DEFINES_SVH
`define PHY_CONTROL_ADDR   5'h00
`define PHY_CONTROL_RESET  16'h3100
`define BIT_REG_RESET      15
`define BIT_LOOPBACK       14
`define BIT_SPEED          13
`define BIT_ANEG_EN        12
`define BIT_POWER_DOWN     11
`define BIT_ISOLATE        10
`define BIT_ANEG_RESTART   9
`define BIT_DUPLEX         8
`define BIT_COLL_TEST      7
`define RSVD_MASK          16'h007F
`endif

/* File: phy_control_pkg.sv */
// types shared by the phy control register block
// assumes phy_control_defines.svh is on the include path
package phy_control_pkg;
  typedef struct packed {
    logic        req;
    logic        write;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } mgmt_req_t;
  typedef struct packed {
    logic loopbackEnable;
    logic speedSelect;
    logic autonegEnable;
    logic powerDown;
    logic isolate;
    logic fullDuplex;
    logic collisionTestEnable;
  } phy_mode_t;
endpackage

/* File: phy_control_register.sv */
// phy control register at management address zero
// assumes one-cycle management requests from the mac, synchronous to sys_clk
//
// How it works
// - register resets to 0x3100, normal operation without software setup
// - field defaults give speed 100, autoneg on, full duplex at reset
// - duplex bit 8 set selects full duplex
// - duplex bit 8 clear selects half duplex
// - software writes and autoneg result both update the duplex bit
// - collision-test bit 7 set enables collision test mode
// - collision-test bit sets on transmit start, clears on transmit halt
// - write data comes from mgmt_write_data; read data to mgmt_read_data
`timescale 1ns/10ps
`include "phy_control_defines.svh"
module phy_control_register
  import phy_control_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire mgmt_req_t   mgmtReq,
  input  wire logic [15:0] mgmt_write_data,
  input  wire logic        anegDone,
  input  wire logic        anegFullDuplex,
  input  wire logic        txStart,
  input  wire logic        txHalt,
  output logic [15:0]      mgmt_read_data,
  output logic             readValid,
  output phy_mode_t        phyMode,
  output logic             regResetPulse,
  output logic             autonegRestartPulse
);
  // ---------------------------------------------
  // register state
  // ---------------------------------------------
  logic [15:0] ctrl_q, ctrl_d;
  logic [15:0] rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d;
  logic        rst_pulse_q, rst_pulse_d;
  logic        aneg_pulse_q, aneg_pulse_d;
  logic        hit;
  logic        wr;

  always_comb begin
    hit = mgmtReq.req && (mgmtReq.addr == `PHY_CONTROL_ADDR);
    wr = hit && mgmtReq.write;
    ctrl_d = ctrl_q;
    rst_pulse_d = 1'b0;
    aneg_pulse_d = 1'b0;
    rvalid_d = mgmtReq.req && !mgmtReq.write;
    rdata_d = rdata_q;
    if (mgmtReq.req && !mgmtReq.write) begin
      rdata_d = hit ? ctrl_q : 16'h0000;
    end
    if (wr) begin
      // reserved bits stored as written, software keeps them zero
      ctrl_d = mgmt_write_data;
      rst_pulse_d = mgmt_write_data[`BIT_REG_RESET];
      aneg_pulse_d = mgmt_write_data[`BIT_ANEG_RESTART];
      ctrl_d[`BIT_REG_RESET] = 1'b0;
      ctrl_d[`BIT_ANEG_RESTART] = 1'b0;
    end
    if (anegDone) begin
      ctrl_d[`BIT_DUPLEX] = anegFullDuplex;
    end
    // halt beats start so a frame never leaves the test bit stuck
    if (txStart) begin
      ctrl_d[`BIT_COLL_TEST] = 1'b1;
    end
    if (txHalt) begin
      ctrl_d[`BIT_COLL_TEST] = 1'b0;
    end
    if (wr && mgmt_write_data[`BIT_REG_RESET]) begin
      ctrl_d = `PHY_CONTROL_RESET;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `PHY_CONTROL_RESET;
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
      rst_pulse_q <= 1'b0;
      aneg_pulse_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      rst_pulse_q <= rst_pulse_d;
      aneg_pulse_q <= aneg_pulse_d;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign mgmt_read_data = rdata_q;
  assign readValid = rvalid_q;
  assign regResetPulse = rst_pulse_q;
  assign autonegRestartPulse = aneg_pulse_q;
  assign phyMode.loopbackEnable = ctrl_q[`BIT_LOOPBACK];
  assign phyMode.speedSelect = ctrl_q[`BIT_SPEED];
  assign phyMode.autonegEnable = ctrl_q[`BIT_ANEG_EN];
  assign phyMode.powerDown = ctrl_q[`BIT_POWER_DOWN];
  assign phyMode.isolate = ctrl_q[`BIT_ISOLATE];
  assign phyMode.fullDuplex = ctrl_q[`BIT_DUPLEX];
  assign phyMode.collisionTestEnable = ctrl_q[`BIT_COLL_TEST];

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  a_reset_value: assert property (@(posedge sys_clk)
    $rose(rst_n) |-> ctrl_q == `PHY_CONTROL_RESET)
    else $error("control not at reset value");
  a_default_mode: assert property (@(posedge sys_clk)
    $rose(rst_n) |-> phyMode.autonegEnable && phyMode.speedSelect && !phyMode.powerDown)
    else $error("reset mode not normal");
  a_full_duplex: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr && mgmt_write_data[`BIT_DUPLEX] && !anegDone && !mgmt_write_data[`BIT_REG_RESET]
      |=> phyMode.fullDuplex)
    else $error("full duplex not driven");
  a_half_duplex: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr && !mgmt_write_data[`BIT_DUPLEX] && !anegDone && !mgmt_write_data[`BIT_REG_RESET]
      |=> !phyMode.fullDuplex)
    else $error("half duplex not driven");
  a_aneg_duplex: assert property (@(posedge sys_clk) disable iff (!rst_n)
    anegDone && !(wr && mgmt_write_data[`BIT_REG_RESET])
      |=> ctrl_q[`BIT_DUPLEX] == $past(anegFullDuplex))
    else $error("negotiated duplex lost");
  a_sw_duplex: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr && !anegDone && !mgmt_write_data[`BIT_REG_RESET]
      |=> ctrl_q[`BIT_DUPLEX] == $past(mgmt_write_data[`BIT_DUPLEX]))
    else $error("written duplex lost");
  a_coll_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hit && !mgmtReq.write
      |=> mgmt_read_data[`BIT_COLL_TEST] == $past(phyMode.collisionTestEnable))
    else $error("collision test mode mismatch");
  a_coll_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    txStart && !txHalt && !(wr && mgmt_write_data[`BIT_REG_RESET])
      |=> phyMode.collisionTestEnable)
    else $error("collision test not set on start");
  a_coll_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    txHalt |=> !phyMode.collisionTestEnable)
    else $error("collision test not cleared on halt");
  a_self_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr && mgmt_write_data[`BIT_ANEG_RESTART]
      |=> autonegRestartPulse && !ctrl_q[`BIT_ANEG_RESTART])
    else $error("restart not self clearing");
  a_read_back: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hit && !mgmtReq.write |=> readValid && mgmt_read_data == $past(ctrl_q))
    else $error("read data wrong");

  // ---------------------------------------------
  // checks: management port
  // ---------------------------------------------
  // a read answers for any address, so the mac never waits on a hole
  a_valid_any: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mgmtReq.req && !mgmtReq.write |=> readValid)
    else $error("read not answered");
  a_valid_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(mgmtReq.req && !mgmtReq.write) |=> !readValid)
    else $error("read valid without read");
  a_rdata_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(mgmtReq.req && !mgmtReq.write) |=> $stable(mgmt_read_data))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mgmtReq.req && !mgmtReq.write && mgmtReq.addr != `PHY_CONTROL_ADDR
      |=> mgmt_read_data == 16'h0000)
    else $error("unmapped read not zero");
  a_idle_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wr && !anegDone && !txStart && !txHalt |=> $stable(ctrl_q))
    else $error("control changed with no cause");
  a_sw_fields: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr && !mgmt_write_data[`BIT_REG_RESET]
      |=> ctrl_q[`BIT_LOOPBACK:`BIT_ISOLATE]
          == $past(mgmt_write_data[`BIT_LOOPBACK:`BIT_ISOLATE]))
    else $error("written mode fields lost");
  // reserved bits kept as written; the mac is trusted to send zeros
  a_reserved_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr && !mgmt_write_data[`BIT_REG_RESET]
      |=> (ctrl_q & `RSVD_MASK) == ($past(mgmt_write_data) & `RSVD_MASK))
    else $error("reserved bits not kept");

  // ---------------------------------------------
  // checks: commands and events
  // ---------------------------------------------
  a_reg_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr && mgmt_write_data[`BIT_REG_RESET]
      |=> regResetPulse && ctrl_q == `PHY_CONTROL_RESET)
    else $error("register reset not applied");
  a_reset_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(wr && mgmt_write_data[`BIT_REG_RESET]) |=> !regResetPulse)
    else $error("register reset pulse stuck");
  a_restart_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(wr && mgmt_write_data[`BIT_ANEG_RESTART]) |=> !autonegRestartPulse)
    else $error("restart pulse stuck");
  a_cmd_bits_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl_q[`BIT_REG_RESET] && !ctrl_q[`BIT_ANEG_RESTART])
    else $error("command bit left set");
  a_duplex_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wr && !anegDone |=> $stable(phyMode.fullDuplex))
    else $error("duplex changed with no cause");
  // negotiation only touches duplex, so a late result cannot undo other settings
  a_aneg_fields: assert property (@(posedge sys_clk) disable iff (!rst_n)
    anegDone && !wr && !txStart && !txHalt
      |=> $stable(ctrl_q[`BIT_REG_RESET:`BIT_ANEG_RESTART]) && $stable(ctrl_q[`BIT_COLL_TEST:0]))
    else $error("negotiation touched other fields");
  a_coll_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr && !txStart && !txHalt && !mgmt_write_data[`BIT_REG_RESET]
      |=> phyMode.collisionTestEnable == $past(mgmt_write_data[`BIT_COLL_TEST]))
    else $error("written collision test lost");
  a_coll_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wr && !txStart && !txHalt |=> $stable(phyMode.collisionTestEnable))
    else $error("collision test changed with no cause");
  a_tx_fields: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (txStart || txHalt) && !wr && !anegDone
      |=> $stable(ctrl_q[`BIT_REG_RESET:`BIT_DUPLEX]) && $stable(ctrl_q[`BIT_COLL_TEST-1:0]))
    else $error("transmit event touched other fields");

  // ---------------------------------------------
  // checks: reset release
  // ---------------------------------------------
  a_reset_outputs: assert property (@(posedge sys_clk)
    $rose(rst_n) |-> !readValid && !regResetPulse && !autonegRestartPulse
      && mgmt_read_data == 16'h0000)
    else $error("outputs not quiet after reset");
  a_reset_fields: assert property (@(posedge sys_clk)
    $rose(rst_n) |-> phyMode.fullDuplex && !phyMode.loopbackEnable && !phyMode.isolate
      && !phyMode.collisionTestEnable)
    else $error("reset fields not normal");
endmodule

/* File: mac_mgmt_model.sv */
// mac-side management model: issues one-cycle register requests
// assumes sys_clk from the bench; the bench calls xfer hierarchically
`timescale 1ns/10ps
module mac_mgmt_model
  import phy_control_pkg::*;
(
  input  wire logic   sys_clk,
  output mgmt_req_t   mgmtReq,
  output logic [15:0] mgmt_write_data
);
  initial begin
    mgmtReq = '0;
    mgmt_write_data = 16'hFFFF;
  end
  // data line shows junk between requests, so a stale word cannot pass
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    mgmtReq <= '{req: 1'b1, write: wr, addr: a, wdata: 16'h0000};
    mgmt_write_data <= d & 16'hFF80;
    @(posedge sys_clk);
    mgmtReq.req <= 1'b0;
    mgmt_write_data <= ~d;
  endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the phy control register
// assumes mac_mgmt_model drives the management requests
`timescale 1ns/10ps
module testbench
  import phy_control_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        anegFullDuplex = 1'b1;
  logic [2:0]  evt = 3'h0;
  mgmt_req_t   mgmtReq;
  logic [15:0] mgmtWriteData;
  logic [15:0] rdData;
  logic        readValid;
  logic        regResetPulse;
  logic        autonegRestartPulse;
  phy_mode_t   phyMode;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;
  always #10 sys_clk = ~sys_clk;
  mac_mgmt_model mac_mgmt_model_inst (.sys_clk(sys_clk), .mgmtReq(mgmtReq),
    .mgmt_write_data(mgmtWriteData));
  phy_control_register phy_control_register_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .mgmtReq(mgmtReq), .mgmt_write_data(mgmtWriteData), .anegDone(evt[2]),
    .anegFullDuplex(anegFullDuplex), .txStart(evt[1]), .txHalt(evt[0]),
    .mgmt_read_data(rdData), .readValid(readValid), .phyMode(phyMode),
    .regResetPulse(regResetPulse), .autonegRestartPulse(autonegRestartPulse));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    mac_mgmt_model_inst.xfer(1'b0, a, 16'h0000);
    #1 chk({15'h0000, readValid}, 16'h0001);
    chk(rdData, exp);
  endtask
  task automatic wr(input logic [15:0] d);
    mac_mgmt_model_inst.xfer(1'b1, 5'h00, d);
    #1;
  endtask
  // one-cycle event pulses: aneg done, tx start, tx halt
  task automatic ev(input logic [2:0] e);
    @(posedge sys_clk);
    evt <= e;
    @(posedge sys_clk);
    evt <= 3'h0;
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      give_verdict;
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(5'h00, 16'h3100);
    chk({9'h000, phyMode}, 16'h0032);
    wr(16'h0000);
    chk({15'h0000, phyMode.fullDuplex}, 16'h0000);
    wr(16'h0100);
    chk({15'h0000, phyMode.fullDuplex}, 16'h0001);
    rd(5'h00, 16'h0100);
    ev(3'h2);
    #1 chk({15'h0000, phyMode.collisionTestEnable}, 16'h0001);
    rd(5'h00, 16'h0180);
    ev(3'h3);
    rd(5'h00, 16'h0100);
    @(posedge sys_clk) anegFullDuplex <= 1'b0;
    ev(3'h4);
    rd(5'h00, 16'h0000);
    @(posedge sys_clk) rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(5'h00, 16'h3100);
    wr(16'h0200);
    chk({15'h0000, autonegRestartPulse}, 16'h0001);
    rd(5'h00, 16'h0000);
    rd(5'h01, 16'h0000);
    wr(16'h7C00);
    chk({9'h000, phyMode}, 16'h007C);
    rd(5'h00, 16'h7C00);
    wr(16'h8000);
    chk({15'h0000, regResetPulse}, 16'h0001);
    rd(5'h00, 16'h3100);
    give_verdict;
  end
endmodule
